// [dsw_regs.svh]
// Data-space decoder constants: address map, field positions, program counter and stack sizes.
// Assumes an 8-bit data space and a 12-bit program space.
`ifndef DSW_REGS_SVH
`define DSW_REGS_SVH

`define DSW_PC_W 12
`define DSW_STACK_DEPTH 6
`define DSW_BANK_LO 8'h00
`define DSW_BANK_HI 8'h3F
`define DSW_WIN_LO 8'h40
`define DSW_WIN_HI 8'h7F
`define DSW_CORE_LO 8'h80
`define DSW_CORE_HI 8'h83
`define DSW_RAM_LO 8'h84
`define DSW_RAM_HI 8'hBF
`define DSW_WINSEL_ADDR 8'hC9
`define DSW_BANKSEL_ADDR 8'hE8
`define DSW_ACC_ADDR 8'hFF
`define DSW_WIN_BASE_MSB 5
`define DSW_RAMP2_BIT 4
`define DSW_EEP_BIT 0
`define DSW_RAMP2_VAL 8'h10
`define DSW_EEP_VAL 8'h01
`define DSW_MEM_RAMP2 2'h0
`define DSW_MEM_EEP 2'h1
`define DSW_MEM_CORE 2'h2
`define DSW_MEM_ACC 8'hC0
`define DSW_UNDEF_DATA 8'h00
`define DSW_PC_STEP 12'h001

`endif

// [dsw_pkg.sv]
// Types shared by the data-space decoder and its bench.
// Assumes dsw_regs.svh is compiled alongside.
package dsw_pkg;

	// Data-space request from the core
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dsw_dreq_t;

	// Program counter operations
	typedef enum logic [2:0] {
		DSW_PC_HOLD = 3'b000,
		DSW_PC_INC = 3'b001,
		DSW_PC_JUMP = 3'b010,
		DSW_PC_CALL = 3'b011,
		DSW_PC_RET = 3'b100,
		DSW_PC_IRQ = 3'b101
	} dsw_pc_op_t;

	// Data-space regions
	typedef enum logic [2:0] {
		DSW_R_BANK = 3'b000,
		DSW_R_WIN = 3'b001,
		DSW_R_MEM = 3'b010,
		DSW_R_WINSEL = 3'b011,
		DSW_R_BANKSEL = 3'b100,
		DSW_R_NONE = 3'b101
	} dsw_region_t;

	// Decoded access
	typedef struct packed {
		dsw_region_t cls;
		logic [7:0] maddr;
	} dsw_dec_t;

endpackage

// [dsw_mem.sv]
// Byte storage behind the data space: bank pages, core registers, general RAM.
// Assumes one write port and one read port on the same clock.
`timescale 1ns/1ps
module dsw_mem (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic we,
	input wire logic [7:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] raddr,
	output logic [7:0] rdata
);

	logic [7:0] mem [0:255];
	logic [7:0] rdata_reg;

	// Array write, contents not reset
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read data
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= mem[raddr];
		end
	end

	assign rdata = rdata_reg;

endmodule

// [dsw_decoder.sv]
// Data-space decoder with read-only program-memory window, program counter and return stack.
// Assumes a core on mclk issuing one access per cycle and program memory answering combinationally.
`timescale 1ns/1ps
`include "dsw_regs.svh"

module dsw_decoder (
	input wire logic mclk,
	input wire logic resetn,
	input dsw_pkg::dsw_dreq_t dreq,
	output logic [7:0] rdata,
	output logic rvalid,
	input dsw_pkg::dsw_pc_op_t pc_op,
	input wire logic [11:0] pc_target,
	output logic [11:0] program_counter,
	output logic [11:0] pm_addr,
	output logic pm_rd,
	input wire logic [7:0] pm_rdata,
	input wire logic readout_protect,
	input wire logic ext_rd,
	input wire logic [11:0] ext_addr,
	output logic [7:0] ext_rdata,
	output logic ext_valid,
	output logic ext_refused
);
	import dsw_pkg::*;

	logic [5:0] window_base_bits;
	logic [5:0] window_base_next;
	logic [7:0] bank_select_reg;
	logic [7:0] bank_select_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic [11:0] pm_addr_reg, pm_addr_next;
	logic pm_rd_reg, pm_rd_next;
	dsw_region_t s1_cls_reg, s1_cls_next;
	logic s1_ext_reg, s1_ext_next;
	logic [7:0] ext_rdata_reg, ext_rdata_next;
	logic ext_valid_reg, ext_valid_next;
	logic ext_refused_reg, ext_refused_next;
	logic prot_meta_reg, prot_reg;
	logic [11:0] program_counter_reg, program_counter_next;
	logic [11:0] stack_reg [0:`DSW_STACK_DEPTH-1];
	logic [11:0] stack_next [0:`DSW_STACK_DEPTH-1];
	logic push, pop;
	logic [11:0] push_val;
	dsw_dec_t dec;
	logic mem_we;
	logic [7:0] mem_rdata;
	logic win_rd;
	logic [7:0] rdata_out_sel;
	logic rdata_valid_reg;

	// Map a data address to its region and storage address; banks only in 00h-3Fh
	function automatic dsw_dec_t decode(input logic [7:0] a, input logic [7:0] bank);
		dsw_dec_t d;
		d.cls = DSW_R_NONE;
		d.maddr = 8'h00;
		if (a <= `DSW_BANK_HI) begin
			d.maddr = {`DSW_MEM_RAMP2, a[5:0]};
			if (bank == `DSW_RAMP2_VAL) begin
				d.cls = DSW_R_BANK;
			end else if (bank == `DSW_EEP_VAL) begin
				d.cls = DSW_R_BANK;
				d.maddr = {`DSW_MEM_EEP, a[5:0]};
			end
		end else if (a <= `DSW_WIN_HI) begin
			d.cls = DSW_R_WIN;
		end else if (a <= `DSW_RAM_HI) begin
			d.cls = DSW_R_MEM;
			d.maddr = {`DSW_MEM_CORE, a[5:0]};
		end else if (a == `DSW_ACC_ADDR) begin
			d.cls = DSW_R_MEM;
			d.maddr = `DSW_MEM_ACC;
		end else if (a == `DSW_WINSEL_ADDR) begin
			d.cls = DSW_R_WINSEL;
		end else if (a == `DSW_BANKSEL_ADDR) begin
			d.cls = DSW_R_BANKSEL;
		end
		return d;
	endfunction

	// Data-space decode, kept apart from program and stack addressing
	always_comb begin
		dec = decode(dreq.addr, bank_select_reg);
		win_rd = dreq.rd && !dreq.wr && (dec.cls == DSW_R_WIN);
		mem_we = dreq.wr && ((dec.cls == DSW_R_BANK) || (dec.cls == DSW_R_MEM));
	end

	dsw_mem u_mem (
		.mclk(mclk),
		.resetn(resetn),
		.we(mem_we),
		.waddr(dec.maddr),
		.wdata(dreq.wdata),
		.raddr(dec.maddr),
		.rdata(mem_rdata)
	);

	// Write-only select registers
	always_comb begin
		window_base_next = window_base_bits;
		bank_select_next = bank_select_reg;
		if (dreq.wr && dec.cls == DSW_R_WINSEL) begin
			window_base_next = dreq.wdata[`DSW_WIN_BASE_MSB:0];
		end
		if (dreq.wr && dec.cls == DSW_R_BANKSEL) begin
			bank_select_next = dreq.wdata;
		end
	end

	// Select registers keep their contents through reset
	always_ff @(posedge mclk) begin
		window_base_bits <= window_base_next;
		bank_select_reg <= bank_select_next;
	end

	// Program-memory port: window reads first, then external readout
	always_comb begin
		pm_addr_next = pm_addr_reg;
		pm_rd_next = 1'b0;
		s1_ext_next = 1'b0;
		ext_refused_next = 1'b0;
		s1_cls_next = dec.cls;
		rvalid_next = dreq.rd && !dreq.wr;
		if (win_rd) begin
			pm_addr_next = {window_base_bits, dreq.addr[5:0]};
			pm_rd_next = 1'b1;
		end else if (ext_rd && !prot_reg) begin
			pm_addr_next = ext_addr;
			pm_rd_next = 1'b1;
			s1_ext_next = 1'b1;
		end
		if (ext_rd && (prot_reg || win_rd)) begin
			ext_refused_next = 1'b1;
		end
	end

	// Answer data two cycles after the request; read data held until the next answer
	always_comb begin
		rdata_next = rdata_reg;
		ext_rdata_next = ext_rdata_reg;
		ext_valid_next = s1_ext_reg;
		if (rvalid_reg) begin
			rdata_next = rdata_out_sel;
		end
		if (s1_ext_reg) begin
			ext_rdata_next = pm_rdata;
		end
	end

	// Read-data selection uses the previous cycle's region
	always_comb begin
		case (s1_cls_reg)
			DSW_R_BANK, DSW_R_MEM: rdata_out_sel = mem_rdata;
			DSW_R_WIN: rdata_out_sel = pm_rdata;
			default: rdata_out_sel = `DSW_UNDEF_DATA;
		endcase
	end

	// Pipeline and answer registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pm_addr_reg <= 12'h000;
			pm_rd_reg <= 1'b0;
			s1_cls_reg <= DSW_R_NONE;
			s1_ext_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			ext_rdata_reg <= 8'h00;
			ext_valid_reg <= 1'b0;
			ext_refused_reg <= 1'b0;
			rdata_reg <= 8'h00;
			rdata_valid_reg <= 1'b0;
		end else begin
			pm_addr_reg <= pm_addr_next;
			pm_rd_reg <= pm_rd_next;
			s1_cls_reg <= s1_cls_next;
			s1_ext_reg <= s1_ext_next;
			rvalid_reg <= rvalid_next;
			ext_rdata_reg <= ext_rdata_next;
			ext_valid_reg <= ext_valid_next;
			ext_refused_reg <= ext_refused_next;
			rdata_reg <= rdata_next;
			rdata_valid_reg <= rvalid_reg;
		end
	end

	// Protection strap through two flops
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prot_meta_reg <= 1'b1;
			prot_reg <= 1'b1;
		end else begin
			prot_meta_reg <= readout_protect;
			prot_reg <= prot_meta_reg;
		end
	end

	// Program counter and stack control
	always_comb begin
		program_counter_next = program_counter_reg;
		push = 1'b0;
		pop = 1'b0;
		push_val = program_counter_reg;
		case (pc_op)
			DSW_PC_INC: program_counter_next = 12'(program_counter_reg + `DSW_PC_STEP);
			DSW_PC_JUMP: program_counter_next = pc_target;
			DSW_PC_CALL: begin
				push = 1'b1;
				push_val = 12'(program_counter_reg + `DSW_PC_STEP);
				program_counter_next = pc_target;
			end
			DSW_PC_IRQ: begin
				push = 1'b1;
				program_counter_next = pc_target;
			end
			DSW_PC_RET: begin
				pop = 1'b1;
				program_counter_next = stack_reg[0];
			end
			default: program_counter_next = program_counter_reg;
		endcase
	end

	// Shift-register stack: push moves entries down, pop moves them up
	genvar gi;
	generate
		for (gi = 0; gi < `DSW_STACK_DEPTH; gi++) begin : g_stack
			always_comb begin
				stack_next[gi] = stack_reg[gi];
				if (push) begin
					stack_next[gi] = (gi == 0) ? push_val : stack_reg[(gi == 0) ? 0 : gi - 1];
				end else if (pop) begin
					stack_next[gi] = stack_reg[(gi == `DSW_STACK_DEPTH - 1) ? gi : gi + 1];
				end
			end
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					stack_reg[gi] <= 12'h000;
				end else begin
					stack_reg[gi] <= stack_next[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			program_counter_reg <= 12'h000;
		end else begin
			program_counter_reg <= program_counter_next;
		end
	end

	assign rdata = rdata_reg;
	assign rvalid = rdata_valid_reg;
	assign program_counter = program_counter_reg;
	assign pm_addr = pm_addr_reg;
	assign pm_rd = pm_rd_reg;
	assign ext_rdata = ext_rdata_reg;
	assign ext_valid = ext_valid_reg;
	assign ext_refused = ext_refused_reg;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_call;
		pc_op == DSW_PC_CALL;
	endsequence
	sequence s_ret;
		pc_op == DSW_PC_RET;
	endsequence

	a_win_address: assert property (win_rd |=> pm_rd && pm_addr == {$past(window_base_bits), $past(dreq.addr[5:0])})
		else $error("window address not formed from base and offset");
	a_win_data: assert property (win_rd |=> ##1 rvalid && rdata == $past(pm_rdata))
		else $error("window read did not return program memory byte");
	a_win_nowrite: assert property (dreq.wr && dreq.addr >= `DSW_WIN_LO && dreq.addr <= `DSW_WIN_HI |-> !mem_we)
		else $error("write to window area reached storage");
	a_winsel_load: assert property (dreq.wr && dreq.addr == `DSW_WINSEL_ADDR |=> window_base_bits == $past(dreq.wdata[5:0]))
		else $error("window register not loaded from low six bits");
	a_winsel_noread: assert property (dreq.rd && !dreq.wr && dreq.addr == `DSW_WINSEL_ADDR |=> ##1 rdata == `DSW_UNDEF_DATA)
		else $error("window register readable");
	a_bank_route: assert property (dreq.addr <= `DSW_BANK_HI && bank_select_reg == `DSW_EEP_VAL |-> dec.maddr == {`DSW_MEM_EEP, dreq.addr[5:0]})
		else $error("EEPROM page routing wrong");
	a_ram_route: assert property (dreq.addr >= `DSW_RAM_LO && dreq.addr <= `DSW_RAM_HI |-> dec.cls == DSW_R_MEM && dec.maddr[7:6] == `DSW_MEM_CORE)
		else $error("general RAM routing wrong");
	a_acc_map: assert property (dreq.addr == `DSW_ACC_ADDR |-> dec.maddr == `DSW_MEM_ACC)
		else $error("accumulator mapping wrong");
	a_reserved_quiet: assert property (dreq.wr && dec.cls == DSW_R_NONE |-> !mem_we ##1 ($stable(window_base_bits) && $stable(bank_select_reg)))
		else $error("reserved access changed state");
	a_prot_refuse: assert property (ext_rd && prot_reg && !win_rd |=> ext_refused && !pm_rd ##1 !ext_valid)
		else $error("protected readout not refused");
	a_pc_step: assert property (pc_op == DSW_PC_INC |=> program_counter == 12'($past(program_counter) + `DSW_PC_STEP))
		else $error("program counter did not step");
	a_call_return: assert property (s_call ##1 s_ret |=> program_counter == 12'($past(program_counter, 2) + `DSW_PC_STEP))
		else $error("return address lost");

endmodule

// [dsw_pmem_model.sv]
// Program memory model facing the decoder's read port.
// Assumes the decoder wants the byte while its read strobe is high.
`timescale 1ns/1ps
module dsw_pmem_model (
	input wire logic mclk,
	input wire logic [11:0] pm_addr,
	input wire logic pm_rd,
	output logic [7:0] pm_rdata
);
	logic [7:0] junk_reg = 8'hA5;
	// Moving idle pattern so a stale byte never passes for an answer
	always @(posedge mclk) begin
		junk_reg <= junk_reg + 8'h5B;
	end
	// Content is a fixed mix of the address bits
	assign pm_rdata = pm_rd ? (pm_addr[7:0] ^ {pm_addr[11:8], 4'hA}) : junk_reg;
endmodule

// [tb.sv]
// Self-checking bench for the data-space decoder.
// Assumes the program memory model answers the decoder's read port.
`timescale 1ns/1ps
module tb;
	import dsw_pkg::*;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	dsw_dreq_t dreq = '0;
	dsw_pc_op_t pc_op = DSW_PC_HOLD;
	logic [11:0] pc_target = 12'h000;
	logic readout_protect = 1'b0;
	logic ext_rd = 1'b0;
	logic [11:0] ext_addr = 12'h000;
	logic [7:0] rdata, pm_rdata, ext_rdata, rd_val, a, d;
	logic rvalid, pm_rd, ext_valid, ext_refused;
	logic [11:0] program_counter, pm_addr;
	int err_total = 0;
	int cmp_count = 0;
	int seed = 32'h54A4;

	// Free-running clock
	always #5 mclk = ~mclk;

	dsw_decoder u_dut (.mclk, .resetn, .dreq, .rdata, .rvalid, .pc_op, .pc_target, .program_counter,
		.pm_addr, .pm_rd, .pm_rdata, .readout_protect, .ext_rd, .ext_addr, .ext_rdata, .ext_valid,
		.ext_refused);

	dsw_pmem_model u_pmem (.mclk, .pm_addr, .pm_rd, .pm_rdata);

	// Byte the memory model holds at a program address
	function automatic logic [7:0] pm_byte(input logic [11:0] ad);
		return ad[7:0] ^ {ad[11:8], 4'hA};
	endfunction

	// Compare and count
	task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// One data-space write
	task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
		@(negedge mclk);
		dreq = '{1'b0, 1'b1, ad, wd};
		@(negedge mclk);
		dreq = '0;
	endtask

	// One data-space read, answer left in rd_val
	task automatic rd(input logic [7:0] ad);
		@(negedge mclk);
		dreq = '{1'b1, 1'b0, ad, 8'h00};
		@(negedge mclk);
		dreq = '0;
		for (int i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge mclk);
		chk("rvalid", {11'h0, rvalid}, 12'h001);
		rd_val = rdata;
	endtask

	// One program counter operation, then the counter value
	task automatic pcop(input dsw_pc_op_t op, input logic [11:0] t, input logic [11:0] exp);
		@(negedge mclk);
		pc_op = op;
		pc_target = t;
		@(negedge mclk);
		pc_op = DSW_PC_HOLD;
		chk("pc", program_counter, exp);
	endtask

	// One external readout attempt
	task automatic ext(input logic [11:0] ad, input logic ok);
		@(negedge mclk);
		ext_rd = 1'b1;
		ext_addr = ad;
		@(negedge mclk);
		ext_rd = 1'b0;
		for (int i = 0; i < 4 && ext_valid !== 1'b1 && ext_refused !== 1'b1; i++) @(negedge mclk);
		chk("ext_valid", {11'h0, ext_valid}, {11'h0, ok});
		chk("ext_refused", {11'h0, ext_refused}, {11'h0, !ok});
		if (ok) chk("ext_rdata", {4'h0, ext_rdata}, {4'h0, pm_byte(ad)});
	endtask

	// Verdict and end of run
	task automatic test_done;
		if (err_total == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (20) @(negedge mclk);
		resetn = 1'b1;
		repeat (4) @(negedge mclk);
		// Window reads: base written first, spare upper bits set, writes to the area ignored
		for (int n = 0; n < 24; n++) begin
			d = (n == 0) ? 8'hFF : ((n == 1) ? 8'h00 : 8'($random(seed)));
			a = 8'h40 | ((n == 0) ? 8'h3F : (8'($random(seed)) & 8'h3F));
			wr(8'hBE, d);
			wr(8'hC9, d);
			rd(a);
			chk("win", {4'h0, rd_val}, {4'h0, pm_byte({d[5:0], a[5:0]})});
			wr(a, ~rd_val);
			rd(a);
			chk("win_wr", {4'h0, rd_val}, {4'h0, pm_byte({d[5:0], a[5:0]})});
		end
		rd(8'hBE);
		chk("win_copy", {4'h0, rd_val}, {4'h0, d});
		rd(8'hC9);
		chk("winsel_rd", {4'h0, rd_val}, 12'h000);
		// General RAM and core registers hold what was written
		for (int n = 0; n < 16; n++) begin
			a = (n == 0) ? 8'hFF : ((n == 1) ? 8'hBF : (8'h80 | (8'($random(seed)) & 8'h3F)));
			d = 8'($random(seed));
			wr(a, d);
			rd(a);
			chk("ram", {4'h0, rd_val}, {4'h0, d});
		end
		// Banked region: two pages kept apart, no page selected means reserved
		a = 8'($random(seed)) & 8'h3F;
		wr(8'hE8, 8'h10);
		wr(a, 8'h11);
		wr(8'hE8, 8'h01);
		wr(a, 8'h22);
		rd(a);
		chk("eep", {4'h0, rd_val}, 12'h022);
		wr(8'hE8, 8'h00);
		wr(a, 8'h33);
		rd(a);
		chk("nobank", {4'h0, rd_val}, 12'h000);
		wr(8'hE8, 8'h10);
		rd(a);
		chk("ramp2", {4'h0, rd_val}, 12'h011);
		rd(8'hE8);
		chk("banksel_rd", {4'h0, rd_val}, 12'h000);
		wr(8'hC3, 8'h5A);
		rd(8'hC3);
		chk("resv", {4'h0, rd_val}, 12'h000);
		// Program counter wraps at 12 bits
		pcop(DSW_PC_JUMP, 12'hFFE, 12'hFFE);
		pcop(DSW_PC_INC, 12'h000, 12'hFFF);
		pcop(DSW_PC_INC, 12'h000, 12'h000);
		// Seven calls, six returns come back newest first
		for (int i = 0; i < 7; i++) pcop(DSW_PC_CALL, 12'h100 + 12'(i * 16), 12'h100 + 12'(i * 16));
		for (int i = 6; i > 0; i--) pcop(DSW_PC_RET, 12'h000, 12'h101 + 12'((i - 1) * 16));
		pcop(DSW_PC_IRQ, 12'h300, 12'h300);
		pcop(DSW_PC_RET, 12'h000, 12'h101);
		// Call followed at once by a return
		@(negedge mclk);
		pc_op = DSW_PC_CALL;
		pc_target = 12'h200;
		@(negedge mclk);
		pc_op = DSW_PC_RET;
		@(negedge mclk);
		pc_op = DSW_PC_HOLD;
		chk("pc_callret", program_counter, 12'h102);
		// External readout open, then refused under protection
		for (int n = 0; n < 4; n++) ext(12'($random(seed)), 1'b1);
		readout_protect = 1'b1;
		repeat (4) @(negedge mclk);
		ext(12'hABC, 1'b0);
		readout_protect = 1'b0;
		repeat (4) @(negedge mclk);
		ext(12'h0FF, 1'b1);
		test_done();
	end

	// Watchdog against a hang
	initial begin
		#200000;
		err_total++;
		test_done();
	end
endmodule
